/* design/clock_gate_cell.sv */
// glitch-free clock gate with its own stop synchronizer and turn-on delay
`timescale 1ns/1ns
module clock_gate_cell #(
  parameter int unsigned ON_DELAY = 0
) (
  input  wire logic src_clk,
  input  wire logic stop_n,
  input  wire logic run,
  output logic      clk_out
);
  import clock_synth_pkg::*;

  localparam logic [2:0] ON_LIMIT = 3'(ON_DELAY);

  logic [1:0] stop_sync;
  logic [1:0] run_sync;
  logic [2:0] delay;
  logic       want;
  logic       enable;

  // ------------------------------------------------------------------
  // synchronizers on the clock being gated
  // ------------------------------------------------------------------
  // two stages each; only the second stage is read below
  always_ff @(posedge src_clk) begin
    stop_sync <= {stop_sync[0], stop_n};
    run_sync  <= {run_sync[0], run};
  end

  // ------------------------------------------------------------------
  // turn-on delay, immediate turn-off
  // ------------------------------------------------------------------
  always_ff @(posedge src_clk) begin
    if (!(stop_sync[1] && run_sync[1])) begin
      want  <= 1'b0;
      delay <= 3'h0;
    end else if (delay >= ON_LIMIT) begin
      want  <= 1'b1;
    end else begin
      delay <= delay + 3'h1;
    end
  end

  // enable moves only in the low phase, so pulses stay whole
  always_ff @(negedge src_clk) begin
    enable <= want;
  end

  assign clk_out = src_clk & enable;

endmodule : clock_gate_cell

/* design/clock_synth_control.sv */
// clock synthesizer control: output gating, power-down, serial config
`timescale 1ns/1ns

// Behaviour
// - power-down low stops all clocks, then crystal and vco, within 3 ms
// - cpu halt low holds cpu clock low, others keep running
// - cpu clock returns at least 3 cpu periods after halt release
// - pci halt low holds stoppable pci clocks low, free pci unaffected
// - frequency pin picks 60 or 66.6 MHz cpu, pci runs at half, 30 or 33.3 MHz
// - low-speed output runs 24 MHz when select 0, 48 MHz when 1
// - stop and power-down transitions give only whole clock pulses
// - both halt inputs act within one free pci rising edge; each gate here needs three rising edges of its own source
// - clocks valid within 3 ms of power-up, low within 2 edges on down; here three CLK edges, then three rising edges of each gate's source
// - reference output stops independently of the counted sequence
// - write begins with start and address D2, acknowledged by device
// - command and count bytes are acknowledged and discarded
// - bytes 0 to 6 in ascending order, may end after any byte
// - every received configuration byte is acknowledged
// - data bytes load successive latches until a stop arrives
// - read address D3 returns byte count then bytes 0 to 6
// - read-back returns the current latch contents
// - serial link runs at 100 kbit/s or less with 8-bit bytes
// - power-on loads defaults; frequency byte resets to zero
// - bits 2 and 7..4 form the 5-bit frequency and spread code
// - frequency bit 3 picks latched pin (0) or register code (1)
// - frequency bit 1 enables spread modulation
module clock_synth_control #(
  parameter int unsigned POWER_ON_WAIT = clock_synth_pkg::POWER_ON_CYCLES,
  parameter int unsigned DRAIN_WAIT    = clock_synth_pkg::DRAIN_CYCLES
) (
  input  wire logic                           CLK,
  input  wire logic                           RESET,
  input  wire logic                           VCO_CLK,
  input  wire logic                           REF_SRC_CLK,
  input  wire logic                           USB_SRC_CLK,
  input  wire logic                           POWER_DOWN_N,
  input  wire logic                           CPU_HALT_N,
  input  wire logic                           PCI_HALT_N,
  input  wire logic                           CPU_FREQ_SELECT,
  input  wire logic                           USB_RATE_SELECT,
  input  wire logic                           SERIAL_CLOCK_PIN,
  input  wire logic                           SERIAL_DATA_IN,
  output logic                                SERIAL_DATA_OUT,
  output logic                                SERIAL_DATA_OE,
  output logic                                CPU_CLOCK_OUT,
  output logic [5:0]                          PCI_CLOCK_OUTS,
  output logic                                PCI_FREE_CLOCK_OUT,
  output logic                                REF_CLOCK_OUT,
  output logic                                USB_RATE_CLOCK_OUT,
  output logic                                OSC_ENABLE,
  output clock_synth_pkg::freq_setting_t      FREQ_SETTING
);
  import clock_synth_pkg::*;

  localparam logic [18:0] POWER_ON_LIMIT = 19'(POWER_ON_WAIT);
  localparam logic [18:0] DRAIN_LIMIT    = 19'(DRAIN_WAIT);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [1:0]    pd_sync;
  logic [1:0]    sel_sync;
  logic [2:0]    scl_sync;
  logic [2:0]    sda_sync;
  logic          freq_pin_latched;
  logic          strap_taken;
  power_state_t  pwr_state;
  logic [18:0]   pwr_count;
  logic          clocks_run;
  logic          ref_run;
  serial_state_t ser_state;
  logic [3:0]    bit_count;
  logic [1:0]    phase;
  logic [3:0]    byte_index;
  logic [7:0]    rx_shift;
  logic [7:0]    tx_shift;
  logic          host_ack;
  logic          drive_low;
  logic [7:0]    cfg [CFG_BYTES];
  logic          scl_rise;
  logic          scl_fall;
  logic          start_seen;
  logic          stop_seen;
  logic [1:0]    vco_rst_sync;
  logic [1:0]    usb_rst_sync;
  logic [1:0]    usb_sel_sync;
  logic          pci_div;
  logic          usb_div;
  logic          usb48_gated;
  logic          usb24_gated;
  logic [7:0]    read_data;

  // choose the byte that a read returns at a given position
  function automatic logic [7:0] read_byte(input logic [3:0] index);
    logic [7:0] value;
    value = 8'hFF;
    if (index < 4'(CFG_BYTES)) begin
      value = cfg[index[2:0]];
    end
    return value;
  endfunction : read_byte

  // byte a read hands out next
  always_comb begin
    read_data = read_byte(byte_index);
  end

  // ------------------------------------------------------------------
  // pin synchronizers in the control clock domain
  // ------------------------------------------------------------------
  // third stage of scl and sda serves only the edge detectors
  always_ff @(posedge CLK) begin
    pd_sync  <= {pd_sync[0], POWER_DOWN_N};
    sel_sync <= {sel_sync[0], CPU_FREQ_SELECT};
    scl_sync <= {scl_sync[1:0], SERIAL_CLOCK_PIN};
    sda_sync <= {sda_sync[1:0], SERIAL_DATA_IN};
  end

  assign scl_rise   = scl_sync[1] && !scl_sync[2];
  assign scl_fall   = !scl_sync[1] && scl_sync[2];
  // start and stop: data moves while clock stays high
  assign start_seen = scl_sync[1] && scl_sync[2] && !sda_sync[1]
                      && sda_sync[2];
  assign stop_seen  = scl_sync[1] && scl_sync[2] && sda_sync[1]
                      && !sda_sync[2];

  // ------------------------------------------------------------------
  // frequency pin strap, caught once after reset release
  // ------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      strap_taken      <= 1'b0;
      freq_pin_latched <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken      <= 1'b1;
      freq_pin_latched <= sel_sync[1];
    end
  end

  // ------------------------------------------------------------------
  // frequency setting
  // ------------------------------------------------------------------
  // pin strap only reaches the two plain settings, 60 and 66.6 MHz
  always_ff @(posedge CLK) begin
    if (RESET) begin
      FREQ_SETTING <= '0;
    end else begin
      if (cfg[FREQ_BYTE][FREQ_SRC_BIT]) begin
        FREQ_SETTING.code <= {cfg[FREQ_BYTE][CODE_BIT0],
                              cfg[FREQ_BYTE][CODE_BIT4_HI:CODE_BIT4_LO]};
      end else begin
        FREQ_SETTING.code <= freq_pin_latched ? CODE_66MHZ
                                              : CODE_60MHZ;
      end
      FREQ_SETTING.spread <= cfg[FREQ_BYTE][SPREAD_BIT];
    end
  end

  // ------------------------------------------------------------------
  // power-down sequencing
  // ------------------------------------------------------------------
  // clocks are parked low before the oscillator is cut, then the
  // oscillator gets the full settling time before all clocks but the reference come back
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pwr_state <= PWR_STARTING;
      pwr_count <= '0;
    end else begin
      case (pwr_state)
        PWR_RUN: begin
          pwr_count <= '0;
          if (!pd_sync[1]) begin
            pwr_state <= PWR_DRAIN;
          end
        end
        PWR_DRAIN: begin
          if (pwr_count >= DRAIN_LIMIT) begin
            pwr_state <= PWR_OFF;
            pwr_count <= '0;
          end else begin
            pwr_count <= pwr_count + 19'h1;
          end
        end
        PWR_OFF: begin
          pwr_count <= '0;
          if (pd_sync[1]) begin
            pwr_state <= PWR_STARTING;
          end
        end
        PWR_STARTING: begin
          if (!pd_sync[1]) begin
            pwr_state <= PWR_DRAIN;
            pwr_count <= '0;
          end else if (pwr_count >= POWER_ON_LIMIT) begin
            pwr_state <= PWR_RUN;
            pwr_count <= '0;
          end else begin
            pwr_count <= pwr_count + 19'h1;
          end
        end
        default: begin
          pwr_state <= PWR_STARTING;
          pwr_count <= '0;
        end
      endcase
    end
  end

  // run levels handed across to the output clock domains
  always_ff @(posedge CLK) begin
    if (RESET) begin
      clocks_run <= 1'b0;
      ref_run    <= 1'b0;
      OSC_ENABLE <= 1'b1;
    end else begin
      clocks_run <= (pwr_state == PWR_RUN) && pd_sync[1];
      // reference stops on the pin alone, outside the counted sequence
      ref_run    <= pd_sync[1] && (pwr_state != PWR_OFF);
      OSC_ENABLE <= (pwr_state != PWR_OFF);
    end
  end

  // ------------------------------------------------------------------
  // serial slave state and bit counting
  // ------------------------------------------------------------------
  // sampled link, so the link rate must stay far below CLK
  always_ff @(posedge CLK) begin
    if (RESET || stop_seen) begin
      ser_state <= SER_IDLE;
      bit_count <= 4'h0;
    end else if (start_seen) begin
      ser_state <= SER_ADDR;
      bit_count <= 4'hF;                            // first fall wraps to 0
    end else if (scl_fall && ser_state != SER_IDLE) begin
      if (bit_count == BIT_ACK) begin
        bit_count <= 4'h0;
        case (ser_state)
          SER_ADDR: begin
            if (rx_shift == WRITE_ADDRESS) begin
              ser_state <= SER_WRITE;
            end else if (rx_shift == READ_ADDRESS) begin
              ser_state <= SER_READ;
            end else begin
              ser_state <= SER_IDLE;
            end
          end
          SER_READ: begin
            if (host_ack) begin
              ser_state <= SER_IDLE;
            end
          end
          SER_WRITE: ser_state <= SER_WRITE;
          default:   ser_state <= SER_IDLE;
        endcase
      end else begin
        bit_count <= bit_count + 4'h1;
      end
    end
  end

  // receive shifter and host acknowledge sampling on clock rise
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_shift <= 8'h00;
      host_ack <= 1'b1;
    end else if (scl_rise) begin
      if (bit_count < BIT_ACK) begin
        rx_shift <= {rx_shift[6:0], sda_sync[1]};
      end else begin
        host_ack <= sda_sync[1];                    // high means no ack
      end
    end
  end

  // ------------------------------------------------------------------
  // byte position tracking
  // ------------------------------------------------------------------
  // phase counts the two leading bytes of a write, byte_index the data
  always_ff @(posedge CLK) begin
    if (RESET || start_seen) begin
      phase      <= 2'h0;
      byte_index <= 4'h0;
    end else if (scl_fall && bit_count == BIT_ACK) begin
      if (ser_state == SER_WRITE) begin
        if (phase < PHASE_DATA) begin
          phase <= phase + 2'h1;
        end else if (byte_index <= LAST_CFG) begin
          byte_index <= byte_index + 4'h1;
        end
      end else if (ser_state == SER_READ && !host_ack) begin
        byte_index <= byte_index + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // configuration latches
  // ------------------------------------------------------------------
  // a byte lands once its eighth bit is in; extras past byte 6 drop
  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        cfg[i] <= CFG_RESET[i];
      end
    end else if (scl_fall && bit_count == BIT_LAST
                 && ser_state == SER_WRITE && phase == PHASE_DATA
                 && byte_index <= LAST_CFG) begin
      cfg[byte_index[2:0]] <= rx_shift;
    end
  end

  // ------------------------------------------------------------------
  // data line drive
  // ------------------------------------------------------------------
  // open drain: the pin is only ever pulled low, a one is released
  always_ff @(posedge CLK) begin
    if (RESET || stop_seen || start_seen) begin
      drive_low <= 1'b0;
      tx_shift  <= 8'hFF;
    end else if (scl_fall) begin
      if (bit_count == BIT_LAST) begin
        if (ser_state == SER_ADDR) begin
          drive_low <= (rx_shift == WRITE_ADDRESS)
                       || (rx_shift == READ_ADDRESS);
        end else if (ser_state == SER_WRITE) begin
          drive_low <= 1'b1;
        end else begin
          drive_low <= 1'b0;                        // host acks here
        end
      end else if (bit_count == BIT_ACK) begin
        if (ser_state == SER_ADDR && rx_shift == READ_ADDRESS) begin
          tx_shift  <= {BLOCK_COUNT[6:0], 1'b1};
          drive_low <= !BLOCK_COUNT[7];
        end else if (ser_state == SER_READ && !host_ack) begin
          tx_shift  <= {read_data[6:0], 1'b1};
          drive_low <= !read_data[7];
        end else begin
          drive_low <= 1'b0;
        end
      end else if (ser_state == SER_READ) begin
        tx_shift  <= {tx_shift[6:0], 1'b1};
        drive_low <= !tx_shift[7];
      end
    end
  end

  assign SERIAL_DATA_OUT = 1'b0;
  assign SERIAL_DATA_OE  = drive_low;

  // ------------------------------------------------------------------
  // output clock domains: reset synchronizers and dividers
  // ------------------------------------------------------------------
  // reset is carried into each source domain before the dividers use it
  always_ff @(posedge VCO_CLK) begin
    vco_rst_sync <= {vco_rst_sync[0], RESET};
  end

  // pci clocks run at half the cpu source
  always_ff @(posedge VCO_CLK) begin
    if (vco_rst_sync[1]) begin
      pci_div <= 1'b0;
    end else begin
      pci_div <= !pci_div;
    end
  end

  always_ff @(posedge USB_SRC_CLK) begin
    usb_rst_sync <= {usb_rst_sync[0], RESET};
    usb_sel_sync <= {usb_sel_sync[0], USB_RATE_SELECT};
  end

  always_ff @(posedge USB_SRC_CLK) begin
    if (usb_rst_sync[1]) begin
      usb_div <= 1'b0;
    end else begin
      usb_div <= !usb_div;
    end
  end

  // ------------------------------------------------------------------
  // gated outputs
  // ------------------------------------------------------------------
  clock_gate_cell #(.ON_DELAY(CPU_ON_DELAY)) cpu_gate (
    .src_clk (VCO_CLK),
    .stop_n  (CPU_HALT_N),
    .run     (clocks_run),
    .clk_out (CPU_CLOCK_OUT)
  );

  // six stoppable pci outputs share one halt input
  for (genvar g = 0; g < 6; g++) begin : pci_stoppable
    clock_gate_cell #(.ON_DELAY(PCI_ON_DELAY)) pci_gate (
      .src_clk (pci_div),
      .stop_n  (PCI_HALT_N),
      .run     (clocks_run),
      .clk_out (PCI_CLOCK_OUTS[g])
    );
  end

  clock_gate_cell #(.ON_DELAY(PCI_ON_DELAY)) pci_free_gate (
    .src_clk (pci_div),
    .stop_n  (1'b1),
    .run     (clocks_run),
    .clk_out (PCI_FREE_CLOCK_OUT)
  );

  clock_gate_cell #(.ON_DELAY(0)) ref_gate (
    .src_clk (REF_SRC_CLK),
    .stop_n  (1'b1),
    .run     (ref_run),
    .clk_out (REF_CLOCK_OUT)
  );

  // each rate has its own gate; swapping rates mid-run may cut a pulse
  clock_gate_cell #(.ON_DELAY(0)) usb48_gate (
    .src_clk (USB_SRC_CLK),
    .stop_n  (1'b1),
    .run     (clocks_run),
    .clk_out (usb48_gated)
  );

  clock_gate_cell #(.ON_DELAY(0)) usb24_gate (
    .src_clk (usb_div),
    .stop_n  (1'b1),
    .run     (clocks_run),
    .clk_out (usb24_gated)
  );

  assign USB_RATE_CLOCK_OUT = usb_sel_sync[1] ? usb48_gated
                                              : usb24_gated;

endmodule : clock_synth_control

/* design/clock_synth_pkg.sv */
// constants and types shared by the clock synthesizer control files
package clock_synth_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_RATE_MHZ     = 125;
  localparam int unsigned POWER_ON_TIME_US = 3000;   // longest power-on time
  // longest time times the clock rate gives a whole number of cycles
  localparam int unsigned POWER_ON_CYCLES  = POWER_ON_TIME_US * CLK_RATE_MHZ;
  // cycles allowed for every gated output to settle low before osc stops
  localparam int unsigned DRAIN_CYCLES     = 64;
  localparam int unsigned CPU_ON_DELAY     = 3;      // cpu turn-on periods
  localparam int unsigned PCI_ON_DELAY     = 0;      // pci extra periods

  // ------------------------------------------------------------------
  // serial interface
  // ------------------------------------------------------------------
  localparam logic [7:0] WRITE_ADDRESS = 8'hD2;
  localparam logic [7:0] READ_ADDRESS  = 8'hD3;
  localparam int unsigned CFG_BYTES    = 7;
  localparam logic [7:0] BLOCK_COUNT   = 8'h07;      // returned byte count
  localparam logic [3:0] LAST_CFG      = 4'h6;       // highest byte index
  localparam logic [3:0] BIT_ACK       = 4'h8;       // ack slot of a byte
  localparam logic [3:0] BIT_LAST      = 4'h7;       // eighth data bit
  localparam logic [1:0] PHASE_DATA    = 2'h2;       // after cmd and count

  // ------------------------------------------------------------------
  // configuration bytes and fields
  // ------------------------------------------------------------------
  localparam int unsigned FREQ_BYTE    = 0;
  localparam int unsigned FREQ_SRC_BIT = 3;          // 1 = register code
  localparam int unsigned SPREAD_BIT   = 1;          // 1 = spread on
  localparam int unsigned CODE_BIT4_HI = 7;          // code bits 3..0
  localparam int unsigned CODE_BIT4_LO = 4;
  localparam int unsigned CODE_BIT0    = 2;          // code bit 4
  localparam logic [7:0] CFG_RESET [CFG_BYTES] = '{
    8'h00, 8'hFC, 8'hF0, 8'hFC, 8'h00, 8'h00, 8'h06};
  localparam logic [4:0] CODE_60MHZ = 5'h00;         // 60 / 30 MHz
  localparam logic [4:0] CODE_66MHZ = 5'h04;         // 66.6 / 33.3 MHz

  // frequency setting handed to the synthesizer core
  typedef struct packed {
    logic [4:0] code;
    logic       spread;
  } freq_setting_t;

  typedef enum logic [3:0] {
    SER_IDLE  = 4'b0001,
    SER_ADDR  = 4'b0010,
    SER_WRITE = 4'b0100,
    SER_READ  = 4'b1000
  } serial_state_t;

  typedef enum logic [3:0] {
    PWR_RUN      = 4'b0001,
    PWR_DRAIN    = 4'b0010,
    PWR_OFF      = 4'b0100,
    PWR_STARTING = 4'b1000
  } power_state_t;

endpackage : clock_synth_pkg

/* verif/clock_synth_control_chk.sv */
// port checker for the clock synthesizer control block
`timescale 1ns/1ns
module clock_synth_control_chk (
  input wire logic                           CLK,
  input wire logic                           RESET,
  input wire logic                           POWER_DOWN_N,
  input wire logic                           CPU_HALT_N,
  input wire logic                           PCI_HALT_N,
  input wire logic                           SERIAL_CLOCK_PIN,
  input wire logic                           SERIAL_DATA_OE,
  input wire logic                           CPU_CLOCK_OUT,
  input wire logic [5:0]                     PCI_CLOCK_OUTS,
  input wire logic                           PCI_FREE_CLOCK_OUT,
  input wire logic                           REF_CLOCK_OUT,
  input wire logic                           OSC_ENABLE,
  input wire clock_synth_pkg::freq_setting_t FREQ_SETTING
);
  import clock_synth_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // halt windows outlast the synchronizer latency
  AST_CPU_HALT: assert property ((!CPU_HALT_N)[*8] ##1 (!CPU_HALT_N)[*8]
    |-> !CPU_CLOCK_OUT) else $error("cpu clock not held low");
  AST_PCI_HALT: assert property ((!PCI_HALT_N)[*8] ##1 (!PCI_HALT_N)[*8]
    ##1 (!PCI_HALT_N)[*8] |-> PCI_CLOCK_OUTS == 6'h00)
    else $error("pci clocks not held low");
  AST_PD_LOW: assert property ((!POWER_DOWN_N)[*8] ##1 (!POWER_DOWN_N)[*8]
    ##1 (!POWER_DOWN_N)[*8] |-> !CPU_CLOCK_OUT && PCI_CLOCK_OUTS == 6'h00)
    else $error("clocks run in power down");
  // a 7 ns high phase can never be seen on two 8 ns samples
  AST_CPU_PULSE: assert property (CPU_CLOCK_OUT |=> !CPU_CLOCK_OUT)
    else $error("stretched cpu pulse");
  AST_OSC_STOP: assert property ($fell(OSC_ENABLE) |-> !POWER_DOWN_N
    && !CPU_CLOCK_OUT && !PCI_FREE_CLOCK_OUT) else $error("osc stopped early");
  AST_OSC_OFF: assert property (!OSC_ENABLE |-> !REF_CLOCK_OUT
    && !CPU_CLOCK_OUT) else $error("clock out while osc off");
  AST_ACK_STABLE: assert property (SERIAL_CLOCK_PIN[*6]
    |-> $stable(SERIAL_DATA_OE)) else $error("data moved in clock high");
  AST_FREQ_RST: assert property ($fell(RESET) |-> FREQ_SETTING == 6'h00)
    else $error("frequency setting not cleared");
  cover property ($rose(CPU_HALT_N));
  cover property ($fell(OSC_ENABLE));
  cover property ($rose(SERIAL_DATA_OE));
endmodule : clock_synth_control_chk

bind clock_synth_control clock_synth_control_chk u_chk (.CLK, .RESET,
  .POWER_DOWN_N, .CPU_HALT_N, .PCI_HALT_N, .SERIAL_CLOCK_PIN,
  .SERIAL_DATA_OE, .CPU_CLOCK_OUT, .PCI_CLOCK_OUTS, .PCI_FREE_CLOCK_OUT,
  .REF_CLOCK_OUT, .OSC_ENABLE, .FREQ_SETTING);

/* verif/clock_synth_control_test.sv */
// self-checking bench for the clock synthesizer control block
`timescale 1ns/1ns
module clock_synth_control_test;
  import clock_synth_pkg::*;
  logic CLK, RESET, VCO_CLK, REF_SRC_CLK, USB_SRC_CLK, POWER_DOWN_N;
  logic CPU_HALT_N, PCI_HALT_N, CPU_FREQ_SELECT, USB_RATE_SELECT, scl;
  logic sda_drive, sda_wire, SERIAL_DATA_OUT, SERIAL_DATA_OE, ack;
  logic CPU_CLOCK_OUT, PCI_FREE_CLOCK_OUT, REF_CLOCK_OUT, OSC_ENABLE;
  logic USB_RATE_CLOCK_OUT;
  logic [5:0] PCI_CLOCK_OUTS;
  logic [7:0] rx;
  logic [7:0] exp [7];
  freq_setting_t FREQ_SETTING;
  int bad_count = 0, checked = 0, cycles = 0, cpu_e, pci_e, free_e, ref_e, usb_e;
  // open-drain line with pull-up
  assign sda_wire = sda_drive & (~SERIAL_DATA_OE | SERIAL_DATA_OUT);
  clock_synth_control #(.POWER_ON_WAIT(50), .DRAIN_WAIT(40)) DUT (
    .CLK, .RESET, .VCO_CLK, .REF_SRC_CLK, .USB_SRC_CLK, .POWER_DOWN_N,
    .CPU_HALT_N, .PCI_HALT_N, .CPU_FREQ_SELECT, .USB_RATE_SELECT,
    .SERIAL_CLOCK_PIN(scl), .SERIAL_DATA_IN(sda_wire), .SERIAL_DATA_OUT,
    .SERIAL_DATA_OE, .CPU_CLOCK_OUT, .PCI_CLOCK_OUTS, .PCI_FREE_CLOCK_OUT,
    .REF_CLOCK_OUT, .USB_RATE_CLOCK_OUT, .OSC_ENABLE, .FREQ_SETTING);
  serial_host_model host (.clk(CLK), .sda_wire, .scl, .sda_drive);
  initial begin
    CLK = 0;
    forever #4 CLK = ~CLK;
  end
  // vco clock 15 ns, phase offset from the control clock
  initial begin
    VCO_CLK = 0;
    forever begin
      #8 VCO_CLK = 1;
      #7 VCO_CLK = 0;
    end
  end
  always #35 REF_SRC_CLK = ~REF_SRC_CLK;
  always #10 USB_SRC_CLK = ~USB_SRC_CLK;
  // edge counts judge whether each output runs; pci only by output 0
  always @(posedge CPU_CLOCK_OUT) cpu_e++;
  always @(posedge PCI_CLOCK_OUTS[0]) pci_e++;
  always @(posedge PCI_FREE_CLOCK_OUT) free_e++;
  always @(posedge REF_CLOCK_OUT) ref_e++;
  always @(posedge USB_RATE_CLOCK_OUT) usb_e++;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic window(input int n);
    {cpu_e, pci_e, free_e, ref_e, usb_e} = '0;
    repeat (n) @(posedge CLK);
  endtask : window
  task automatic check(input string what, input logic [31:0] seen, want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, want, seen);
    end
  endtask : check
  task automatic read_all(input logic [7:0] want [7]);
    host.start();
    host.xfer(READ_ADDRESS, 1'b1, rx, ack);
    check("rd ack", ack, 1'b0);
    host.xfer(8'hFF, 1'b0, rx, ack);
    check("rd count", rx, BLOCK_COUNT);
    for (int i = 0; i < 7; i++) begin
      host.xfer(8'hFF, 1'b0, rx, ack);
      check("rd byte", rx, want[i]);
    end
    host.stop();
  endtask : read_all
  // address, dummy command and count, then data bytes
  task automatic write_bytes(input logic [7:0] addr, input logic [7:0] d [$]);
    host.start();
    host.xfer(addr, 1'b1, rx, ack);
    check("wr addr ack", ack, addr !== WRITE_ADDRESS);
    foreach (d[i]) begin
      host.xfer(d[i], 1'b1, rx, ack);
      check("wr ack", ack, 1'b0);
    end
    host.stop();
  endtask : write_bytes
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    {RESET, POWER_DOWN_N, CPU_HALT_N, PCI_HALT_N} = 4'hF;
    {REF_SRC_CLK, USB_SRC_CLK, CPU_FREQ_SELECT, USB_RATE_SELECT} = 4'h3;
    repeat (3) @(posedge CLK);
    RESET <= 0;
    repeat (120) @(posedge CLK);
    check("strap", FREQ_SETTING, {CODE_66MHZ, 1'b0});
    window(120);
    check("cpu 2x pci", cpu_e inside {[2*free_e-2:2*free_e+2]}, 1);
    check("usb 48", usb_e inside {[46:50]}, 1);
    USB_RATE_SELECT <= 0;
    window(20);
    window(120);
    check("usb 24", usb_e inside {[22:26]}, 1);
    CPU_HALT_N <= 0;
    PCI_HALT_N <= 0;
    window(40);
    window(60);
    check("halted", cpu_e + pci_e, 0);
    check("free runs", free_e > 0 && ref_e > 0, 1);
    CPU_HALT_N <= 1;
    window(6);
    check("cpu on delay", cpu_e, 0);
    window(40);
    check("resumed", cpu_e > 0 && pci_e == 0, 1);
    PCI_HALT_N <= 1;
    window(40);
    check("pci resumed", pci_e > 0, 1);
    POWER_DOWN_N <= 0;
    repeat (60) @(posedge CLK);
    check("osc off", OSC_ENABLE, 1'b0);
    window(40);
    check("all stopped", cpu_e + pci_e + free_e + ref_e, 0);
    POWER_DOWN_N <= 1;
    window(120);
    window(40);
    check("clocks back", cpu_e > 0 && free_e > 0 && ref_e > 0, 1);
    read_all(CFG_RESET);
    write_bytes(WRITE_ADDRESS, '{8'hAA, 8'h55, 8'hFA, 8'h12});
    check("reg code", FREQ_SETTING, 6'b011111);
    exp = CFG_RESET;
    exp[0] = 8'hFA;
    exp[1] = 8'h12;
    read_all(exp);
    write_bytes(WRITE_ADDRESS, '{8'hAA, 8'h55, 8'h88});
    check("code 01000", FREQ_SETTING, 6'b010000);
    write_bytes(8'hA0, '{});
    write_bytes(WRITE_ADDRESS, '{8'hAA, 8'h55, 8'h00});
    check("pin code", FREQ_SETTING, {CODE_66MHZ, 1'b0});
    wrap_up();
  end
endmodule : clock_synth_control_test

/* verif/serial_host_model.sv */
// serial host model: start, stop and bytes on the config link
`timescale 1ns/1ns
module serial_host_model (
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drive
);
  initial begin
    scl = 1'b1;
    sda_drive = 1'b1;
  end
  // 20 cycle half bit, a rate far above the 100 kbit/s link ceiling
  task automatic half();
    repeat (20) @(posedge clk);
  endtask : half
  task automatic start();
    half();
    sda_drive <= 1'b0;
    half();
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    @(posedge clk);
    sda_drive <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_drive <= 1'b1;
  endtask : stop
  // data moves one cycle after clock falls, read at end of high
  task automatic put_bit(input logic b, output logic seen);
    @(posedge clk);
    sda_drive <= b;
    half();
    scl <= 1'b1;
    half();
    seen = sda_wire;
    scl <= 1'b0;
  endtask : put_bit
  // msb first, then the ack slot; 1 releases the wire
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(ack_in, ack);
  endtask : xfer
endmodule : serial_host_model
